// file: hdl/swp_status_perm.sv
// status register, write gating and device memory for the dual-network pot
`timescale 1ns/100ps
`default_nettype none
module swp_status_perm #(
    parameter int unsigned NV_CYCLES = swp_pkg::NV_WRITE_CYC
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire swp_pkg::swp_req_s REQ,
    input  wire logic              HV_VALID,
    input  wire logic [1:0]        HV_SEL,
    input  wire logic              HV_VALUE,
    input  wire logic              WP_N,
    output swp_pkg::swp_rsp_s      RSP,
    output logic [8:0]             STATUS,
    output logic [8:0]             TERMINAL_CONNECT_CTL_OUT,
    output logic [8:0]             WIPER0_OUT,
    output logic [8:0]             WIPER1_OUT
);
    logic [8:0]  mem_ff [0:15];
    logic        nv_write_in_progress_ff;
    swp_pkg::swp_wstate_e state_ff;
    swp_pkg::swp_wstate_e nxt_state;
    logic [swp_pkg::CNT_W-1:0] cnt_ff;
    logic [swp_pkg::CNT_W-1:0] nxt_cnt;
    logic        nv_wp_ff;
    logic        net0_lock_flag_ff;
    logic        net1_lock_flag_ff;
    logic        wp_pin_lvl;
    logic        load_done_ff;

    // volatile-location test used by gate and write-cycle start
    function automatic logic is_volatile(input logic [3:0] a);
        is_volatile = (a == swp_pkg::ADR_VWIPER0) ||
                      (a == swp_pkg::ADR_VWIPER1) ||
                      (a == swp_pkg::ADR_TERMINAL_CONNECT_CTL)    ||
                      (a == swp_pkg::ADR_STATUS);
    endfunction

    swp_sync u_wp_sync (
        .clk      (CLK),
        .rst      (RST),
        .async_in (WP_N),
        .level_out(wp_pin_lvl)
    );

    // protect state: inverted pin OR stored bit
    wire wp_active = ~wp_pin_lvl | nv_wp_ff;                    // R7
    wire [3:0] a   = REQ.addr;
    wire is_nv     = ~is_volatile(a);
    wire is_net0   = (a == swp_pkg::ADR_VWIPER0) ||
                     (a == swp_pkg::ADR_NVWIPER0);
    wire is_net1   = (a == swp_pkg::ADR_VWIPER1) ||
                     (a == swp_pkg::ADR_NVWIPER1);
    // busy cycle admits volatile addresses only
    wire busy_block = nv_write_in_progress_ff & is_nv;          // R3
    wire lock_block = (is_net0 & net0_lock_flag_ff) |           // R5
                      (is_net1 & net1_lock_flag_ff);            // R4
    // protect only reaches nonvolatile targets, never volatile
    wire wp_block   = wp_active & is_nv;                        // R8 R9
    // status is read-only, so ordinary writes to it are refused
    wire ro_block   = (a == swp_pkg::ADR_STATUS);               // R10
    wire wr_refused = REQ.wr & (busy_block | lock_block |
                                wp_block | ro_block);
    wire wr_ok      = REQ.wr & ~wr_refused;
    wire rd_refused = REQ.rd & busy_block;                      // R3
    wire start_nv   = wr_ok & is_nv;

    // terminal-control write keeps locked nibbles as they were
    wire [8:0] keep_mask =
        (net0_lock_flag_ff ? swp_pkg::TERMINAL_CONNECT_CTL_NET0_MASK : 9'h000) |  // R5
        (net1_lock_flag_ff ? swp_pkg::TERMINAL_CONNECT_CTL_NET1_MASK : 9'h000);   // R4
    wire [8:0] terminal_connect_ctl_new = (REQ.data & ~keep_mask) |
                          (mem_ff[swp_pkg::ADR_TERMINAL_CONNECT_CTL] & keep_mask);

    // live status word
    wire [8:0] status_now = {swp_pkg::RESERVED_ONES,            // R1
                             nv_write_in_progress_ff,           // R2
                             net1_lock_flag_ff,
                             net0_lock_flag_ff,
                             wp_active};
    wire [8:0] rd_data = (a == swp_pkg::ADR_STATUS) ? status_now // R11
                                                    : mem_ff[a];

    // write-cycle sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            swp_pkg::WR_IDLE: begin
                if (start_nv) begin
                    nxt_state = swp_pkg::WR_BUSY;
                    nxt_cnt   = swp_pkg::CNT_W'(NV_CYCLES - 1);
                end
            end
            swp_pkg::WR_BUSY: begin
                if (cnt_ff == '0) begin
                    nxt_state = swp_pkg::WR_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            default: begin
                nxt_state = swp_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff                <= swp_pkg::WR_IDLE;
            cnt_ff                  <= '0;
            nv_write_in_progress_ff <= 1'b0;                    // R2
        end else begin
            state_ff                <= nxt_state;
            cnt_ff                  <= nxt_cnt;
            nv_write_in_progress_ff <= (nxt_state == swp_pkg::WR_BUSY); // R2
        end
    end

    // stored special bits: sel 0 protect, 1 lock0, 2 lock1
    // these model nonvolatile cells, so reset does not clear them
    logic nv_wp_cell_ff;
    logic nv_l0_cell_ff;
    logic nv_l1_cell_ff;
    always_ff @(posedge CLK) begin
        if (HV_VALID && !nv_write_in_progress_ff) begin         // R10
            case (HV_SEL)
                2'd0:    nv_wp_cell_ff <= HV_VALUE;
                2'd1:    nv_l0_cell_ff <= HV_VALUE;
                2'd2:    nv_l1_cell_ff <= HV_VALUE;
                default: nv_wp_cell_ff <= nv_wp_cell_ff;
            endcase
        end
    end

    // live flags follow last programming, reload from cells after reset
    wire hv_go = HV_VALID & ~nv_write_in_progress_ff;
    always_ff @(posedge CLK) begin
        if (RST) begin
            load_done_ff      <= 1'b0;
            nv_wp_ff          <= 1'b0;
            net0_lock_flag_ff <= 1'b0;
            net1_lock_flag_ff <= 1'b0;
        end else if (!load_done_ff) begin
            load_done_ff      <= 1'b1;                          // R6
            nv_wp_ff          <= nv_wp_cell_ff === 1'b1;
            net0_lock_flag_ff <= nv_l0_cell_ff === 1'b1;
            net1_lock_flag_ff <= nv_l1_cell_ff === 1'b1;
        end else if (hv_go) begin
            if (HV_SEL == 2'd0) nv_wp_ff <= HV_VALUE;           // R6
            if (HV_SEL == 2'd1) net0_lock_flag_ff <= HV_VALUE;
            if (HV_SEL == 2'd2) net1_lock_flag_ff <= HV_VALUE;
        end
    end

    // memory: refused writes touch nothing; volatile reload at reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            mem_ff[swp_pkg::ADR_TERMINAL_CONNECT_CTL] <= swp_pkg::TERMINAL_CONNECT_CTL_RESET;
            mem_ff[swp_pkg::ADR_VWIPER0] <= mem_ff[swp_pkg::ADR_NVWIPER0];
            mem_ff[swp_pkg::ADR_VWIPER1] <= mem_ff[swp_pkg::ADR_NVWIPER1];
        end else if (wr_ok) begin                               // R12
            if (a == swp_pkg::ADR_TERMINAL_CONNECT_CTL) begin
                mem_ff[a] <= terminal_connect_ctl_new;
            end else begin
                mem_ff[a] <= REQ.data;
            end
        end
    end

    // registered outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            RSP        <= '0;
            STATUS     <= {swp_pkg::RESERVED_ONES, 4'h0};
            TERMINAL_CONNECT_CTL_OUT   <= swp_pkg::TERMINAL_CONNECT_CTL_RESET;
            WIPER0_OUT <= swp_pkg::VWIPER_RESET;
            WIPER1_OUT <= swp_pkg::VWIPER_RESET;
        end else begin
            RSP.valid   <= REQ.wr | REQ.rd;
            RSP.refused <= wr_refused | rd_refused;
            RSP.data    <= (REQ.rd & ~rd_refused) ? rd_data : 9'h000;
            STATUS      <= status_now;
            TERMINAL_CONNECT_CTL_OUT    <= mem_ff[swp_pkg::ADR_TERMINAL_CONNECT_CTL];
            WIPER0_OUT  <= mem_ff[swp_pkg::ADR_VWIPER0];
            WIPER1_OUT  <= mem_ff[swp_pkg::ADR_VWIPER1];
        end
    end
endmodule : swp_status_perm
`default_nettype wire

// file: hdl/swp_pkg.sv
// package: memory map, status layout and transport structs for the status/write-permission block
// Notes on behaviour
// R1 - read-only 9-bit status at address 05h; bits 8 to 4 always read one
// R2 - status bit 3 set while a nonvolatile write cycle runs; zero after reset
// R3 - during a write cycle only addresses 00h, 01h, 04h, 05h are accepted
// R4 - lock bit 2 blocks writes to network 1 wipers and its four terminal bits
// R5 - lock bit 1 blocks writes to network 0 wipers and its four terminal bits
// R6 - lock flags follow last lock programming and reload from stored value at reset
// R7 - status bit 0 is OR of inverted protect pin and stored protect bit
// R8 - write protect refuses every nonvolatile write, wipers and general purpose
// R9 - write protect never blocks volatile wiper or terminal-control changes
// R10 - lock and protect flags change only through high-voltage commands
// R11 - a read of address 05h returns the current flag values
// R12 - a blocked write leaves the stored value unchanged
package swp_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 9;
    localparam logic [3:0] ADR_VWIPER0 = 4'h0;
    localparam logic [3:0] ADR_VWIPER1 = 4'h1;
    localparam logic [3:0] ADR_NVWIPER0 = 4'h2;
    localparam logic [3:0] ADR_NVWIPER1 = 4'h3;
    localparam logic [3:0] ADR_TERMINAL_CONNECT_CTL = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h5;
    localparam logic [3:0] ADR_GP_FIRST = 4'h6;
    localparam logic [3:0] ADR_GP_LAST = 4'hF;
    // status field positions
    localparam int unsigned ST_WP_BIT = 0;
    localparam int unsigned ST_LOCK0_BIT = 1;
    localparam int unsigned ST_LOCK1_BIT = 2;
    localparam int unsigned ST_NVWA_BIT = 3;
    localparam logic [4:0] RESERVED_ONES = 5'h1F;
    // terminal-control groups: network 0 low nibble, network 1 next nibble
    localparam logic [8:0] TERMINAL_CONNECT_CTL_NET0_MASK = 9'h00F;
    localparam logic [8:0] TERMINAL_CONNECT_CTL_NET1_MASK = 9'h0F0;
    localparam logic [8:0] TERMINAL_CONNECT_CTL_RESET = 9'h1FF;
    localparam logic [8:0] NVWIPER_RESET = 9'h080;
    localparam logic [8:0] GP_RESET = 9'h0FF;
    localparam logic [8:0] VWIPER_RESET = 9'h080;
    // nonvolatile write cycle time
    localparam int unsigned NV_WRITE_NS = 5000000;
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned NV_WRITE_CYC = NV_WRITE_NS / CLK_NS;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned SYNC_W = 3;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_BUSY = 2'b10
    } swp_wstate_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [8:0] data;
    } swp_req_s;

    typedef struct packed {
        logic       valid;
        logic       refused;
        logic [8:0] data;
    } swp_rsp_s;
endpackage : swp_pkg

// file: hdl/swp_sync.sv
// three-stage synchroniser for an asynchronous pin level
`timescale 1ns/100ps
`default_nettype none
module swp_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      level_out
);
    logic [swp_pkg::SYNC_W-1:0] stage_ff;

    // stage 0 is read only by stage 1; change accepted when 1 and 2 agree
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_ff  <= '1;
            level_out <= 1'b1;
        end else begin
            stage_ff <= {stage_ff[1:0], async_in};
            if (stage_ff[1] == stage_ff[2]) begin
                level_out <= stage_ff[2];
            end
        end
    end
endmodule : swp_sync
`default_nettype wire

// file: verification/swp_status_perm_properties.sv
// checker: port-level properties of the status/write-permission block
`timescale 1ns/100ps
`default_nettype none
module swp_status_perm_chk #(
    parameter int unsigned NV_CYCLES = 8
) (
    input wire logic              CLK,
    input wire logic              RST,
    input wire swp_pkg::swp_req_s REQ,
    input wire logic              WP_N,
    input wire swp_pkg::swp_rsp_s RSP,
    input wire logic [8:0]        STATUS,
    input wire logic [8:0]        WIPER0_OUT,
    input wire logic [8:0]        WIPER1_OUT
);
    // request decode; the trailing flag sample proves it was live at take
    wire nv = !(REQ.addr inside {4'h0, 4'h1, 4'h4, 4'h5});
    wire wr = REQ.wr;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_ones_fixed: assert property (STATUS[8:4] == 5'h1F)
        else $error("status reserved bits not all one");
    chk_rsp_timing: assert property ((wr || REQ.rd) |=> RSP.valid)
        else $error("no response one cycle after request");
    chk_status_ro: assert property (
        wr && REQ.addr == 4'h5 |=> RSP.refused)
        else $error("status write accepted");
    chk_busy_gate: assert property (
        (wr && nv && STATUS[3] ##1 STATUS[3]) |-> RSP.refused)
        else $error("nonvolatile write accepted while busy");
    chk_wp_gate: assert property (
        (wr && nv && STATUS[0] ##1 STATUS[0]) |-> RSP.refused)
        else $error("nonvolatile write accepted under protect");
    chk_lock0_wiper: assert property (
        (wr && REQ.addr == 4'h0 && STATUS[1] ##1 STATUS[1])
        |-> RSP.refused && $stable(WIPER0_OUT) ##1 $stable(WIPER0_OUT))
        else $error("locked wiper 0 written");
    chk_lock1_wiper: assert property (
        (wr && REQ.addr == 4'h1 && STATUS[2] ##1 STATUS[2])
        |-> RSP.refused && $stable(WIPER1_OUT) ##1 $stable(WIPER1_OUT))
        else $error("locked wiper 1 written");
    // pin passes a three-flop synchroniser, so allow six quiet samples
    chk_wp_pin: assert property ((!WP_N && !RST)[*6] |-> STATUS[0])
        else $error("protect pin low but status shows unprotected");
endmodule // swp_status_perm_chk
bind swp_status_perm swp_status_perm_chk #(.NV_CYCLES(NV_CYCLES)) chk_inst (
    .CLK(CLK), .RST(RST), .REQ(REQ), .WP_N(WP_N), .RSP(RSP),
    .STATUS(STATUS), .WIPER0_OUT(WIPER0_OUT), .WIPER1_OUT(WIPER1_OUT));
`default_nettype wire

// file: verification/swp_host_model.sv
// host controller model: issues one-cycle memory requests
`timescale 1ns/100ps
`default_nettype none
module swp_host_model (
    input  wire logic              clk,
    input  wire swp_pkg::swp_rsp_s rsp,
    output swp_pkg::swp_req_s      req
);
    initial req = '0;
    // held until the taking edge; the answer stands for the cycle after it
    // and is taken before the idle edge overwrites it; never overlaps
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [8:0] d, output swp_pkg::swp_rsp_s r);
        @(posedge clk) #1 req = '{wr: w, rd: !w, addr: a, data: d};
        @(posedge clk) #1 r = rsp;
        req = '0;
        @(posedge clk) #1;
    endtask
endmodule // swp_host_model
`default_nettype wire

// file: verification/swp_status_perm_tb.sv
// testbench: status flags and write gating through host requests
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module swp_status_perm_tb;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              hv_valid = 1'b0;
    logic [1:0]        hv_sel = 2'h0;
    logic              hv_value = 1'b0;
    logic              wp_n = 1'b1;
    swp_pkg::swp_req_s req;
    swp_pkg::swp_rsp_s rsp, r;
    logic [8:0]        status, terminal_connect_ctl, wip0, wip1;
    int                fails = 0;
    int                checks = 0;
    always #4 clk = ~clk;
    swp_host_model swp_host_model_inst (.clk(clk), .rsp(rsp), .req(req));
    swp_status_perm #(.NV_CYCLES(8)) swp_status_perm_inst (
        .CLK(clk), .RST(rst), .REQ(req), .HV_VALID(hv_valid),
        .HV_SEL(hv_sel), .HV_VALUE(hv_value), .WP_N(wp_n), .RSP(rsp),
        .STATUS(status), .TERMINAL_CONNECT_CTL_OUT(terminal_connect_ctl), .WIPER0_OUT(wip0),
        .WIPER1_OUT(wip1));
    task automatic test_done;
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // extra edges after release let the pin synchroniser fill
    task automatic do_reset;
        #1 rst = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [8:0] d, input logic e);
        swp_host_model_inst.xfer(1'b1, a, d, r);
        `CHK("refused", e, r.refused)
    endtask
    task automatic rd(input logic [3:0] a, input logic [8:0] e);
        swp_host_model_inst.xfer(1'b0, a, 9'h000, r);
        `CHK("rdata", e, r.data)
    endtask
    // one high-voltage programming pulse, then time to settle
    task automatic hv(input logic [1:0] s, input logic v);
        @(posedge clk) #1 hv_valid = 1'b1;
        hv_sel = s;
        hv_value = v;
        @(posedge clk) #1 hv_valid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        do_reset();
        `CHK("status", 9'h1F0, status)
        rd(4'h5, 9'h1F0);
        wr(4'h5, 9'h000, 1'b1);
        wr(4'h6, 9'h0AA, 1'b0);
        `CHK("busy", 1'b1, status[3])
        wr(4'h2, 9'h011, 1'b1);
        wr(4'h0, 9'h011, 1'b0);
        rd(4'h0, 9'h011);
        repeat (12) @(posedge clk);
        #1 `CHK("busy", 1'b0, status[3])
        rd(4'h6, 9'h0AA);
        hv(2'h1, 1'b1);
        `CHK("lock0", 1'b1, status[1])
        wr(4'h0, 9'h022, 1'b1);
        `CHK("wiper0", 9'h011, wip0)
        wr(4'h4, 9'h000, 1'b0);
        `CHK("terminal_connect_ctl", 9'h00F, terminal_connect_ctl)
        wr(4'h1, 9'h044, 1'b0);
        hv(2'h2, 1'b1);
        wr(4'h1, 9'h033, 1'b1);
        `CHK("wiper1", 9'h044, wip1)
        wr(4'h4, 9'h1FF, 1'b0);
        `CHK("terminal_connect_ctl", 9'h10F, terminal_connect_ctl)
        hv(2'h1, 1'b0);
        wp_n = 1'b0;
        repeat (8) @(posedge clk);
        #1 `CHK("wp", 1'b1, status[0])
        wr(4'h7, 9'h000, 1'b1);
        wr(4'h0, 9'h055, 1'b0);
        `CHK("wiper0", 9'h055, wip0)
        wp_n = 1'b1;
        hv(2'h0, 1'b1);
        repeat (8) @(posedge clk);
        #1 `CHK("wp", 1'b1, status[0])
        do_reset();
        `CHK("status", 9'h1F5, status)
        test_done();
    end
    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule // swp_status_perm_tb
`default_nettype wire
